// ---- hdl/pdc_top.sv ----
// command input conditioning: filtering, polarity, limits and in-position flag
`timescale 1ns/1ns
module pdc_top (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire pdc_pkg::pdc_cfg_s cfg,
  input  wire logic              cmdPulseIn,
  input  wire logic              cmdDirIn,
  input  wire logic              cwLimitSwitch,
  input  wire logic              ccwLimitSwitch,
  input  wire logic              positionMode,
  input  wire logic [31:0]       posDeviation,
  output logic [14:0]            gearNum4,
  output logic                   stepValid,
  output logic                   stepPositive,
  output logic                   cwTorqueZero,
  output logic                   ccwTorqueZero,
  output logic                   inPositionOutput
);
  localparam int CW = pdc_pkg::FILT_CNT_W;

  logic          cfgLoaded;
  logic [CW-1:0] pulseThresh;
  logic [CW-1:0] dirThresh;
  logic          pulseFilt;
  logic          dirFilt;
  logic          pulsePrev;
  logic          dirPositive;
  logic          stepBlocked;
  logic [31:0]   remaining;

  // filter strengths are taken once after reset release, like a power cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgLoaded   <= 1'b0;
      pulseThresh <= CW'((32'(pdc_pkg::PULSE_FILT_RST) + 1) * pdc_pkg::FILT_STEP_CYC);
      dirThresh   <= CW'((32'(pdc_pkg::DIR_FILT_RST) + 1) * pdc_pkg::FILT_STEP_CYC);
    end else if (!cfgLoaded) begin
      cfgLoaded   <= 1'b1;
      pulseThresh <= CW'((32'(cfg.pulseFilt) + 1) * pdc_pkg::FILT_STEP_CYC);
      dirThresh   <= CW'((32'(cfg.dirFilt) + 1) * pdc_pkg::FILT_STEP_CYC);
    end
  end

  pdc_filter #(.CW(CW)) uPulseFilt (
    .clk       (clk),
    .arst_n    (arst_n),
    .sampleIn  (cmdPulseIn),
    .threshold (pulseThresh),
    .filtOut   (pulseFilt)
  );

  pdc_filter #(.CW(CW)) uDirFilt (
    .clk       (clk),
    .arst_n    (arst_n),
    .sampleIn  (cmdDirIn),
    .threshold (dirThresh),
    .filtOut   (dirFilt)
  );

  // polarity 0 means high is positive; positive travel is taken as clockwise
  assign dirPositive = dirFilt ^ cfg.dirPolarity;
  assign stepBlocked = (cfg.limitMethod == pdc_pkg::PDC_LIMIT_PULSE) &&
                       (dirPositive ? cwLimitSwitch : ccwLimitSwitch);

  // gear numerator passes to the gear stage; 15 bits cover 0..32767 exactly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gearNum4 <= pdc_pkg::GEAR4_RST;
    end else begin
      gearNum4 <= cfg.gearNum4;
    end
  end

  // one step per rising edge of the filtered pulse line, none while stepBlocked is set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulsePrev    <= 1'b0;
      stepValid    <= 1'b0;
      stepPositive <= 1'b0;
    end else begin
      pulsePrev    <= pulseFilt;
      stepValid    <= pulseFilt & ~pulsePrev & ~stepBlocked;
      stepPositive <= dirPositive;
    end
  end

  // torque clamp follows the switch level while method 0 is chosen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cwTorqueZero  <= 1'b0;
      ccwTorqueZero <= 1'b0;
    end else begin
      cwTorqueZero  <= (cfg.limitMethod == pdc_pkg::PDC_LIMIT_TORQUE) & cwLimitSwitch;
      ccwTorqueZero <= (cfg.limitMethod == pdc_pkg::PDC_LIMIT_TORQUE) & ccwLimitSwitch;
    end
  end

  // magnitude of the deviation; the most negative value maps to 32'h80000000, its exact unsigned magnitude
  assign remaining = posDeviation[31] ? (32'h0 - posDeviation) : posDeviation;

  // set at or below range, release past range plus hysteresis or when positionMode is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inPositionOutput <= 1'b0;
    end else if (!positionMode) begin
      inPositionOutput <= 1'b0;
    end else if (remaining <= 32'(cfg.completeRange)) begin
      inPositionOutput <= 1'b1;
    end else if (remaining > 32'(cfg.completeRange) + 32'(cfg.hystWidth)) begin
      inPositionOutput <= 1'b0;
    end
  end

  property p_inpos_set;
    @(posedge clk) disable iff (!arst_n)
      positionMode && remaining <= 32'(cfg.completeRange) |=> inPositionOutput;
  endproperty
  a_inpos_set: assert property (p_inpos_set)
    else $error("in-position not set within range");

  property p_inpos_hold;
    @(posedge clk) disable iff (!arst_n)
      positionMode && inPositionOutput &&
      remaining <= 32'(cfg.completeRange) + 32'(cfg.hystWidth) |=> inPositionOutput;
  endproperty
  a_inpos_hold: assert property (p_inpos_hold)
    else $error("in-position dropped inside hysteresis band");

  property p_inpos_clear;
    @(posedge clk) disable iff (!arst_n)
      remaining > 32'(cfg.completeRange) + 32'(cfg.hystWidth) || !positionMode
      |=> !inPositionOutput;
  endproperty
  a_inpos_clear: assert property (p_inpos_clear)
    else $error("in-position held outside band");

  property p_inpos_mode;
    @(posedge clk) disable iff (!arst_n)
      !positionMode |=> !inPositionOutput;
  endproperty
  a_inpos_mode: assert property (p_inpos_mode)
    else $error("in-position set outside position control");

  property p_block_pulse;
    @(posedge clk) disable iff (!arst_n)
      cfg.limitMethod == pdc_pkg::PDC_LIMIT_PULSE && dirPositive && cwLimitSwitch
      |=> !stepValid;
  endproperty
  a_block_pulse: assert property (p_block_pulse)
    else $error("step passed into active cw limit");

  property p_torque_zero;
    @(posedge clk) disable iff (!arst_n)
      cfg.limitMethod == pdc_pkg::PDC_LIMIT_TORQUE |=> cwTorqueZero == $past(cwLimitSwitch);
  endproperty
  a_torque_zero: assert property (p_torque_zero)
    else $error("cw torque clamp does not follow switch");

  // the ccw side mirrors the cw side; a blocked step must never leak through
  property p_block_ccw;
    @(posedge clk) disable iff (!arst_n)
      cfg.limitMethod == pdc_pkg::PDC_LIMIT_PULSE && !dirPositive && ccwLimitSwitch
      |=> !stepValid;
  endproperty
  a_block_ccw: assert property (p_block_ccw)
    else $error("step passed into active ccw limit");

  property p_torque_ccw;
    @(posedge clk) disable iff (!arst_n)
      cfg.limitMethod == pdc_pkg::PDC_LIMIT_TORQUE |=> ccwTorqueZero == $past(ccwLimitSwitch);
  endproperty
  a_torque_ccw: assert property (p_torque_ccw)
    else $error("ccw torque clamp does not follow switch");

  // with pulse blocking chosen the torque path stays free
  property p_no_clamp;
    @(posedge clk) disable iff (!arst_n)
      cfg.limitMethod == pdc_pkg::PDC_LIMIT_PULSE |=> !cwTorqueZero && !ccwTorqueZero;
  endproperty
  a_no_clamp: assert property (p_no_clamp)
    else $error("torque clamped while pulse blocking chosen");

  property p_dir_pol;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |=> stepPositive == ($past(dirFilt) ^ $past(cfg.dirPolarity));
  endproperty
  a_dir_pol: assert property (p_dir_pol)
    else $error("direction polarity wrong");

  property p_gear;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |=> gearNum4 == $past(cfg.gearNum4);
  endproperty
  a_gear: assert property (p_gear)
    else $error("gear numerator not passed");

  property p_step_edge;
    @(posedge clk) disable iff (!arst_n)
      stepValid |-> $past(pulseFilt) && !$past(pulsePrev);
  endproperty
  a_step_edge: assert property (p_step_edge)
    else $error("step without filtered rising edge");

  property p_step_once;
    @(posedge clk) disable iff (!arst_n)
      stepValid |=> !stepValid;
  endproperty
  a_step_once: assert property (p_step_once)
    else $error("one filtered edge gave two steps");

  property p_thresh_fixed;
    @(posedge clk) disable iff (!arst_n)
      cfgLoaded |=> $stable(pulseThresh) && $stable(dirThresh);
  endproperty
  a_thresh_fixed: assert property (p_thresh_fixed)
    else $error("filter strength changed while running");

  c_step:     cover property (@(posedge clk) disable iff (!arst_n) stepValid);
  c_inpos:    cover property (@(posedge clk) disable iff (!arst_n) $rose(inPositionOutput));
  c_blocked:  cover property (@(posedge clk) disable iff (!arst_n) pulseFilt && stepBlocked);
  c_torque:   cover property (@(posedge clk) disable iff (!arst_n) ccwTorqueZero);
  c_release:  cover property (@(posedge clk) disable iff (!arst_n) $fell(inPositionOutput));
endmodule

// ---- hdl/pdc_filter.sv ----
// constants, settings carrier and the stability filter for the command lines
`timescale 1ns/1ns
package pdc_pkg;
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          MAX_RATE_HZ    = 500_000;
  // one filter step is 80 ns; four steps keep 500 kHz inside its half period
  localparam int          FILT_STEP_NS   = 80;
  localparam int          FILT_STEP_CYC  = (FILT_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          FILT_CNT_W     = 7;
  localparam logic [14:0] GEAR4_RST      = 15'h0000;
  localparam logic        DIR_POL_RST    = 1'h0;
  localparam logic [3:0]  PULSE_FILT_RST = 4'h4;
  localparam logic [3:0]  DIR_FILT_RST   = 4'h4;
  localparam logic        LIMIT_MTH_RST  = 1'h0;
  localparam logic [14:0] COMPLETE_RST   = 15'h0041;
  localparam logic [14:0] HYST_RST       = 15'h1964;

  typedef enum logic {PDC_LIMIT_TORQUE = 1'b0, PDC_LIMIT_PULSE = 1'b1} pdc_limit_e;

  typedef struct packed {
    logic [14:0] gearNum4;
    logic        dirPolarity;
    logic [3:0]  pulseFilt;
    logic [3:0]  dirFilt;
    pdc_limit_e  limitMethod;
    logic [14:0] completeRange;
    logic [14:0] hystWidth;
  } pdc_cfg_s;
endpackage

// level changes only after threshold consecutive samples disagree with it
module pdc_filter #(
  parameter int CW = 7
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          sampleIn,
  input  wire logic [CW-1:0] threshold,
  output logic               filtOut
);
  logic [CW-1:0] stableCnt;

  // any agreeing sample restarts the count, so a glitch never accumulates
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stableCnt <= '0;
      filtOut   <= 1'b0;
    end else if (sampleIn == filtOut) begin
      stableCnt <= '0;
    end else if (stableCnt + 1'b1 >= threshold) begin
      stableCnt <= '0;
      filtOut   <= sampleIn;
    end else begin
      stableCnt <= stableCnt + 1'b1;
    end
  end

  property p_filt_needs_run;
    @(posedge clk) disable iff (!arst_n)
      $changed(filtOut) |-> $past(sampleIn) == filtOut;
  endproperty
  a_filt_needs_run: assert property (p_filt_needs_run)
    else $error("filter changed without matching input");
endmodule

// ---- tb/pdc_ctrl_model.sv ----
// motion controller model: direction setup, then a burst of command pulses
`timescale 1ns/1ns
module pdc_ctrl_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] nSteps,
  input  wire logic       dirLevel,
  input  wire logic [7:0] halfCyc,
  output logic            cmdPulse,
  output logic            cmdDir,
  output logic            busy
);
  // one process owns every output; direction settles longer than its filter first
  initial begin
    cmdPulse = 1'b0;
    cmdDir   = 1'b0;
    busy     = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        @(negedge clk);
        busy   = 1'b1;
        cmdDir = dirLevel;
        repeat (24) @(negedge clk);
        // a short half period is a noisy line that the drive must reject
        for (int i = 0; i < nSteps; i++) begin
          cmdPulse = 1'b1;
          repeat (halfCyc) @(negedge clk);
          cmdPulse = 1'b0;
          repeat (halfCyc) @(negedge clk);
        end
        busy = 1'b0;
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the command conditioning block
`timescale 1ns/1ns
module tb_top;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  pdc_pkg::pdc_cfg_s cfg;
  logic              cmdPulseIn, cmdDirIn, cwLimitSwitch, ccwLimitSwitch, positionMode;
  logic [31:0]       posDeviation;
  logic [14:0]       gearNum4;
  logic              stepValid, stepPositive, cwTorqueZero, ccwTorqueZero, inPositionOutput;
  logic              go = 1'b0, dirLevel = 1'b0, busy, lastPos;
  logic [7:0]        nSteps = 8'h00, halfCyc = 8'h16;
  int                err_count = 0, n_compared = 0, stepCnt = 0, cycles = 0;

  pdc_top u_pdc_top (.clk(clk), .arst_n(arst_n), .cfg(cfg), .cmdPulseIn(cmdPulseIn),
    .cmdDirIn(cmdDirIn), .cwLimitSwitch(cwLimitSwitch), .ccwLimitSwitch(ccwLimitSwitch),
    .positionMode(positionMode), .posDeviation(posDeviation), .gearNum4(gearNum4),
    .stepValid(stepValid), .stepPositive(stepPositive), .cwTorqueZero(cwTorqueZero),
    .ccwTorqueZero(ccwTorqueZero), .inPositionOutput(inPositionOutput));
  pdc_ctrl_model u_pdc_ctrl_model (.clk(clk), .go(go), .nSteps(nSteps), .dirLevel(dirLevel),
    .halfCyc(halfCyc), .cmdPulse(cmdPulseIn), .cmdDir(cmdDirIn), .busy(busy));

  always #10 clk = ~clk;
  // count accepted steps and remember the direction of the last one
  always @(posedge clk) begin
    cycles++;
    if (stepValid === 1'b1) begin
      stepCnt++;
      lastPos = stepPositive;
    end
    if (cycles == 6000) begin
      err_count++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("err_count=%0d n_compared=%0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one burst from the controller, then enough idle time for the last step to land
  task automatic burst(input logic [7:0] n, input logic d, input logic [7:0] h);
    stepCnt  = 0;
    nSteps   = n;
    dirLevel = d;
    halfCyc  = h;
    go       = 1'b1;
    @(posedge busy);
    @(negedge clk);
    go = 1'b0;
    @(negedge busy);
    repeat (30) @(negedge clk);
  endtask

  task automatic t_steps();
    burst(8'h05, 1'b1, 8'h16);
    check(stepCnt, 5);
    check(lastPos, 1);
    cfg.dirPolarity = 1'b1;
    burst(8'h03, 1'b1, 8'h16);
    check(lastPos, 0);
    burst(8'h03, 1'b0, 8'h16);
    check(lastPos, 1);
    cfg.dirPolarity = 1'b0;
    burst(8'h04, 1'b1, 8'h0A);
    check(stepCnt, 0);
  endtask

  task automatic t_limits();
    cwLimitSwitch = 1'b1;
    repeat (2) @(negedge clk);
    check({cwTorqueZero, ccwTorqueZero}, 2'h2);
    cwLimitSwitch  = 1'b0;
    ccwLimitSwitch = 1'b1;
    repeat (2) @(negedge clk);
    check({cwTorqueZero, ccwTorqueZero}, 2'h1);
    cfg.limitMethod = pdc_pkg::PDC_LIMIT_PULSE;
    burst(8'h03, 1'b0, 8'h16);
    check({stepCnt[1:0], ccwTorqueZero}, 3'h0);
    ccwLimitSwitch = 1'b0;
    cwLimitSwitch  = 1'b1;
    burst(8'h03, 1'b0, 8'h16);
    check(stepCnt, 3);
    burst(8'h02, 1'b1, 8'h16);
    check(stepCnt, 0);
    cwLimitSwitch = 1'b0;
  endtask

  // deviations walk down, into the band, out of it and back; negative ones by magnitude
  task automatic t_inpos();
    logic [31:0] dev [8] = '{32'h1F4, 32'h41, 32'h82, 32'h83, 32'h64, 32'hFFFFFFBF,
                              32'hFFFFFF7E, 32'h0};
    logic        exp [8] = '{0, 1, 1, 0, 0, 1, 1, 0};
    positionMode = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 7)
        positionMode = 1'b0;
      posDeviation = dev[i];
      repeat (3) @(negedge clk);
      check(inPositionOutput, exp[i]);
    end
  endtask

  // a new filter strength only counts after a reset, which stands in for a power cycle
  task automatic t_refilter();
    cfg.pulseFilt = 4'h0;
    cfg.dirFilt   = 4'h0;
    burst(8'h03, 1'b1, 8'h0A);
    check(stepCnt, 0);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    check({gearNum4, stepValid, cwTorqueZero}, 17'h0);
    arst_n = 1'b1;
    burst(8'h03, 1'b0, 8'h0A);
    check(stepCnt, 3);
    check(lastPos, 0);
    check(gearNum4, 15'h7FFF);
  endtask

  initial begin
    cfg = '{15'h0000, 1'b0, 4'h4, 4'h4, pdc_pkg::PDC_LIMIT_TORQUE, 15'h0041, 15'h0041};
    {cwLimitSwitch, ccwLimitSwitch, positionMode} = 3'h0;
    posDeviation = 32'h0;
    cfg.gearNum4 = 15'h7FFF;
    repeat (12) @(negedge clk);
    check({gearNum4, stepValid, inPositionOutput}, 17'h0);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    check(gearNum4, 15'h7FFF);
    t_steps();
    t_limits();
    t_inpos();
    t_refilter();
    close_out();
  end
endmodule
